// file: chg_sup_cfg.svh
// Timing and code constants for the charger supervisor logic.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef CHG_SUP_CFG_SVH
`define CHG_SUP_CFG_SVH
`define CLK_PERIOD_NS      10
`define CLK_HZ             100000000
`define BLINK_FAULT_ON_MS  167
`define BLINK_FAULT_OFF_MS 833
`define BLINK_OT_ON_MS     1000
`define BLINK_OT_OFF_MS    1000
`define MS_CYCLES          (`CLK_HZ / 1000)
`define WD_PERIOD_CYC      32'd3200000000
`define SAFE_PERIOD_CYC    32'd3600000000
`define END_QUAL_CYC       32'd1500000000
`define STATE_OFF          3'h0
`define STATE_TRICKLE      3'h1
`define STATE_FAST_CC      3'h2
`define STATE_FAST_CV      3'h3
`define STATE_DONE         3'h4
`define STATE_SAFE_END     3'h5
`define STATE_FAULT        3'h6
`define SYSEN_LDO          2'h0
`define SYSEN_BAT          2'h1
`define SYSEN_WEAK_ISO     2'h2
`define SYSEN_LDO_OR_WEAK  2'h3
`endif

// file: chg_sup_pkg.sv
// Types shared by the charger supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package chg_sup_pkg;
  typedef enum logic [2:0] {
    CH_OFF, CH_TRICKLE, CH_FAST_CC, CH_FAST_CV, CH_DONE, CH_STOPPED, CH_FAULT
  } charge_state_e;
  typedef enum logic [1:0] {
    LED_DARK, LED_ON, LED_BLINK_FAULT, LED_BLINK_HOT
  } led_mode_e;
endpackage

// file: led_pattern.sv
// Indicator blink generator from a free-running counter.
// Assumes synchronous reset copy and one-cycle mode settling.
`include "chg_sup_cfg.svh"
module led_pattern (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire chg_sup_pkg::led_mode_e mode,
  output logic                       led_on
);
  localparam int unsigned FON  = `BLINK_FAULT_ON_MS * `MS_CYCLES;
  localparam int unsigned FPER = (`BLINK_FAULT_ON_MS + `BLINK_FAULT_OFF_MS) * `MS_CYCLES;
  localparam int unsigned TON  = `BLINK_OT_ON_MS * `MS_CYCLES;
  localparam int unsigned TPER = (`BLINK_OT_ON_MS + `BLINK_OT_OFF_MS) * `MS_CYCLES;
  logic [31:0]            cnt;
  chg_sup_pkg::led_mode_e last_mode;
  logic [31:0]            period;
  logic [31:0]            on_len;
  always_comb begin
    period = (mode == chg_sup_pkg::LED_BLINK_HOT) ? TPER : FPER;
    on_len = (mode == chg_sup_pkg::LED_BLINK_HOT) ? TON : FON;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 32'h0;
      last_mode <= chg_sup_pkg::LED_DARK;
    end else begin
      last_mode <= mode;
      if (mode != last_mode || cnt >= period - 32'h1) begin
        cnt <= 32'h0;
      end else begin
        cnt <= cnt + 32'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_on <= 1'b0;
    end else begin
      case (mode)
        chg_sup_pkg::LED_ON:          led_on <= 1'b1;
        chg_sup_pkg::LED_BLINK_FAULT,
        chg_sup_pkg::LED_BLINK_HOT:   led_on <= (mode == last_mode) && (cnt < on_len);
        default:                      led_on <= 1'b0;
      endcase
    end
  end
endmodule

// file: charger_supervisor_logic.sv
// Supervisory logic of a linear battery charger: watchdog, safety timer,
// charge qualification, enables, system-enable and indicator.
// Assumes analogue comparators arrive as asynchronous levels and host
// register bits arrive as same-clock levels and one-cycle write pulses.
// How it works
// - Watchdog starts on first kick or strong battery
// - Watchdog expiry in charger mode starts safety timer
// - Safety start restores default input current limit when charge parameters were set
// - Safety period end stops charging, sets state
// - Low current for full time sets done
// - Current rising again restarts end timer
// - After done, recharge threshold restarts constant voltage
// - Recharge disabled sets recharge-needed status bit
// - Chip disable by register or pin two
// - Charge disable stops charging, regulator keeps running
// - Register enable write overrides pin setting
// - Start limit withholds charging above limit
// - Start limit off after reset, bit enables
// - System enable modes zero and one
// - Mode two: weak battery, no supply, monitor
// - Mode three: regulator, or charging above weak
// - Indicator off, on, or two blink patterns
// - Regulator mode overheat interrupt, then shutdown
// - Shutdown flag sticky until cleared and cooled
// - Early warning flag above warning temperature
// - Fault code six, cleared by fault write
`include "chg_sup_cfg.svh"
module charger_supervisor_logic #(
  parameter logic [31:0] WD_CYCLES   = `WD_PERIOD_CYC,
  parameter logic [31:0] SAFE_CYCLES = `SAFE_PERIOD_CYC,
  parameter logic [31:0] END_CYCLES  = `END_QUAL_CYC
) (
  input  wire logic       CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       WATCHDOG_KICK_BIT_IN,
  input  wire logic       CHIP_DISABLE_BIT_IN,
  input  wire logic       CHIP_DISABLE_PIN_EN_IN,
  input  wire logic       CONFIG_PIN_TWO_IN,
  input  wire logic       CHARGE_ENABLE_BIT_IN,
  input  wire logic       CHARGE_ENABLE_WRITE_IN,
  input  wire logic       CHARGE_PIN_EN_IN,
  input  wire logic       CONFIG_PIN_THREE_IN,
  input  wire logic       START_LIMIT_ENABLE_BIT_IN,
  input  wire logic       RECHARGE_DISABLE_BIT_IN,
  input  wire logic       CHARGE_PARAMS_SET_IN,
  input  wire logic       BATTERY_MONITOR_ENABLE_BIT_IN,
  input  wire logic [1:0] SYSEN_MODE_IN,
  input  wire logic       FAULT_CLEAR_WRITE_IN,
  input  wire logic       TSD_CLEAR_WRITE_IN,
  input  wire logic       TIMER_FAULT_IN,
  input  wire logic       BAT_ABOVE_WEAK_IN,
  input  wire logic       BAT_ABOVE_TRICKLE_IN,
  input  wire logic       BAT_ABOVE_START_LIMIT_IN,
  input  wire logic       BAT_AT_TERMINATION_IN,
  input  wire logic       BAT_SENSE_AT_RECHARGE_IN,
  input  wire logic       CURRENT_BELOW_END_IN,
  input  wire logic       SUPPLY_INPUT_OK_IN,
  input  wire logic       SYSTEM_VOLTAGE_OK_IN,
  input  wire logic       DIE_ABOVE_WARNING_IN,
  input  wire logic       DIE_ABOVE_INTERRUPT_IN,
  input  wire logic       DIE_ABOVE_SHUTDOWN_IN,
  output logic [2:0]      CHARGE_STATE_OUT,
  output logic            CHARGE_DONE_FLAG_OUT,
  output logic            RECHARGE_NEEDED_OUT,
  output logic            ILIM_DEFAULT_OUT,
  output logic            CHARGING_OUT,
  output logic            REGULATOR_ON_OUT,
  output logic            ISO_FET_DISABLE_OUT,
  output logic            SYSTEM_ENABLE_OUT,
  output logic            SYSTEM_ENABLE_OE_OUT,
  output logic            INDICATOR_OUTPUT_OUT,
  output logic            INDICATOR_OUTPUT_OE_OUT,
  output logic            THERMAL_SHUTDOWN_FLAG_OUT,
  output logic            EARLY_WARNING_FLAG_OUT,
  output logic            THERMAL_INT_OUT
);
  localparam int NSYNC = 12;
  logic             rst_meta;
  logic             rst_n;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  logic [NSYNC-1:0] s3;
  logic [NSYNC-1:0] lv;
  logic             pin_two;
  logic             pin_three;
  logic             above_weak;
  logic             above_trk;
  logic             above_lim;
  logic             at_trm;
  logic             at_rch;
  logic             i_low;
  logic             vin_ok;
  logic             sys_ok;
  logic             hot_int;
  logic             hot_sd;
  logic             warn;
  logic             chip_off;
  logic             charge_en;
  logic             override_seen;
  logic             wd_running;
  logic [31:0]      wd_cnt;
  logic             wd_expire;
  logic             safe_running;
  logic [31:0]      safe_cnt;
  logic [31:0]      end_cnt;
  logic             withheld;
  logic             thermal_shutdown_flag;
  chg_sup_pkg::charge_state_e state;
  chg_sup_pkg::charge_state_e next_state;
  chg_sup_pkg::led_mode_e     led_mode;
  logic             charger_mode;
  logic             led_on;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign async_in = {CONFIG_PIN_TWO_IN, CONFIG_PIN_THREE_IN, BAT_ABOVE_WEAK_IN,
                     BAT_ABOVE_TRICKLE_IN, BAT_ABOVE_START_LIMIT_IN,
                     BAT_AT_TERMINATION_IN, BAT_SENSE_AT_RECHARGE_IN,
                     CURRENT_BELOW_END_IN, SUPPLY_INPUT_OK_IN, SYSTEM_VOLTAGE_OK_IN,
                     DIE_ABOVE_INTERRUPT_IN, DIE_ABOVE_SHUTDOWN_IN};
  // Change accepted only when second and third stages agree
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
        lv[i] <= 1'b0;
      end else begin
        s1[i] <= async_in[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          lv[i] <= s3[i];
        end
      end
    end
  end
  assign {pin_two, pin_three, above_weak, above_trk, above_lim, at_trm, at_rch,
          i_low, vin_ok, sys_ok, hot_int, hot_sd} = lv;

  // Warning has its own stage set; kept apart to avoid widening the bus above
  logic w1, w2, w3;
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      w1   <= 1'b0;
      w2   <= 1'b0;
      w3   <= 1'b0;
      warn <= 1'b0;
    end else begin
      w1 <= DIE_ABOVE_WARNING_IN;
      w2 <= w1;
      w3 <= w2;
      if (w2 == w3) begin
        warn <= w3;
      end
    end
  end

  assign chip_off = CHIP_DISABLE_BIT_IN || (CHIP_DISABLE_PIN_EN_IN && pin_two);

  // With pin enable set, pin three controls charging until software first writes the enable bit
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      override_seen <= 1'b0;
    end else if (CHARGE_ENABLE_WRITE_IN) begin
      override_seen <= 1'b1;
    end
  end
  assign charge_en = (override_seen || !CHARGE_PIN_EN_IN) ? CHARGE_ENABLE_BIT_IN
                                                          : pin_three;

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wd_running <= 1'b0;
      wd_cnt     <= 32'h0;
    end else if (chip_off) begin
      wd_running <= 1'b0;
      wd_cnt     <= 32'h0;
    end else begin
      if (WATCHDOG_KICK_BIT_IN || above_weak) begin
        wd_running <= 1'b1;
      end
      if (WATCHDOG_KICK_BIT_IN || !wd_running) begin
        wd_cnt <= 32'h0;
      end else if (wd_cnt < WD_CYCLES) begin
        wd_cnt <= wd_cnt + 32'h1;
      end
    end
  end
  assign wd_expire = wd_running && !WATCHDOG_KICK_BIT_IN && (wd_cnt == WD_CYCLES - 32'h1);

  assign charger_mode = (state == chg_sup_pkg::CH_TRICKLE) ||
                        (state == chg_sup_pkg::CH_FAST_CC) ||
                        (state == chg_sup_pkg::CH_FAST_CV);

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      safe_running     <= 1'b0;
      safe_cnt         <= 32'h0;
      ILIM_DEFAULT_OUT <= 1'b0;
    end else if (chip_off || !charger_mode) begin
      safe_running <= 1'b0;
      safe_cnt     <= 32'h0;
    end else if (wd_expire && !safe_running) begin
      safe_running <= 1'b1;
      safe_cnt     <= 32'h0;
      if (CHARGE_PARAMS_SET_IN) begin
        ILIM_DEFAULT_OUT <= 1'b1;
      end
    end else if (safe_running) begin
      safe_cnt <= safe_cnt + 32'h1;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      end_cnt <= 32'h0;
    end else if (state != chg_sup_pkg::CH_FAST_CV || !i_low) begin
      end_cnt <= 32'h0;
    end else if (end_cnt < END_CYCLES) begin
      end_cnt <= end_cnt + 32'h1;
    end
  end

  // Start limit only checked on the way into a charge cycle
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      withheld <= 1'b0;
    end else if (state == chg_sup_pkg::CH_OFF) begin
      withheld <= START_LIMIT_ENABLE_BIT_IN && above_lim;
    end else begin
      withheld <= 1'b0;
    end
  end

  // Set wins over clear on the same cycle
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      thermal_shutdown_flag <= 1'b0;
    end else if (hot_sd) begin
      thermal_shutdown_flag <= 1'b1;
    end else if (TSD_CLEAR_WRITE_IN) begin
      thermal_shutdown_flag <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      chg_sup_pkg::CH_OFF: begin
        if (charge_en && !thermal_shutdown_flag && vin_ok && !withheld &&
            !(START_LIMIT_ENABLE_BIT_IN && above_lim)) begin
          next_state = above_trk ? chg_sup_pkg::CH_FAST_CC : chg_sup_pkg::CH_TRICKLE;
        end
      end
      chg_sup_pkg::CH_TRICKLE: begin
        if (above_trk) begin
          next_state = chg_sup_pkg::CH_FAST_CC;
        end
      end
      chg_sup_pkg::CH_FAST_CC: begin
        if (at_trm) begin
          next_state = chg_sup_pkg::CH_FAST_CV;
        end
      end
      chg_sup_pkg::CH_FAST_CV: begin
        if (end_cnt == END_CYCLES) begin
          next_state = chg_sup_pkg::CH_DONE;
        end
      end
      chg_sup_pkg::CH_DONE: begin
        if (at_rch && !RECHARGE_DISABLE_BIT_IN) begin
          next_state = chg_sup_pkg::CH_FAST_CV;
        end
      end
      chg_sup_pkg::CH_STOPPED: begin
        if (at_rch && !RECHARGE_DISABLE_BIT_IN) begin
          next_state = chg_sup_pkg::CH_FAST_CV;
        end
      end
      chg_sup_pkg::CH_FAULT: begin
        if (FAULT_CLEAR_WRITE_IN) begin
          next_state = chg_sup_pkg::CH_OFF;
        end
      end
      default: next_state = chg_sup_pkg::CH_OFF;
    endcase
    if (state != chg_sup_pkg::CH_FAULT) begin
      if (TIMER_FAULT_IN && charger_mode) begin
        next_state = chg_sup_pkg::CH_FAULT;
      end else if (charger_mode && safe_running && safe_cnt == SAFE_CYCLES - 32'h1) begin
        next_state = chg_sup_pkg::CH_STOPPED;
      end
    end
    if (chip_off || !charge_en || thermal_shutdown_flag || !vin_ok) begin
      next_state = chg_sup_pkg::CH_OFF;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state <= chg_sup_pkg::CH_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      CHARGE_STATE_OUT     <= `STATE_OFF;
      CHARGE_DONE_FLAG_OUT <= 1'b0;
      RECHARGE_NEEDED_OUT  <= 1'b0;
      CHARGING_OUT         <= 1'b0;
    end else begin
      case (next_state)
        chg_sup_pkg::CH_TRICKLE: CHARGE_STATE_OUT <= `STATE_TRICKLE;
        chg_sup_pkg::CH_FAST_CC: CHARGE_STATE_OUT <= `STATE_FAST_CC;
        chg_sup_pkg::CH_FAST_CV: CHARGE_STATE_OUT <= `STATE_FAST_CV;
        chg_sup_pkg::CH_DONE:    CHARGE_STATE_OUT <= `STATE_DONE;
        chg_sup_pkg::CH_STOPPED: CHARGE_STATE_OUT <= `STATE_SAFE_END;
        chg_sup_pkg::CH_FAULT:   CHARGE_STATE_OUT <= `STATE_FAULT;
        default:                 CHARGE_STATE_OUT <= `STATE_OFF;
      endcase
      CHARGING_OUT         <= (next_state == chg_sup_pkg::CH_TRICKLE) ||
                              (next_state == chg_sup_pkg::CH_FAST_CC) ||
                              (next_state == chg_sup_pkg::CH_FAST_CV);
      CHARGE_DONE_FLAG_OUT <= (next_state == chg_sup_pkg::CH_DONE);
      RECHARGE_NEEDED_OUT  <= (state == chg_sup_pkg::CH_DONE) && at_rch &&
                              RECHARGE_DISABLE_BIT_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      REGULATOR_ON_OUT          <= 1'b0;
      THERMAL_INT_OUT           <= 1'b0;
      THERMAL_SHUTDOWN_FLAG_OUT <= 1'b0;
      EARLY_WARNING_FLAG_OUT    <= 1'b0;
      ISO_FET_DISABLE_OUT       <= 1'b0;
      SYSTEM_ENABLE_OUT         <= 1'b0;
    end else begin
      REGULATOR_ON_OUT          <= !chip_off && !thermal_shutdown_flag && vin_ok;
      THERMAL_INT_OUT           <= !chip_off && !charger_mode && vin_ok && hot_int;
      THERMAL_SHUTDOWN_FLAG_OUT <= thermal_shutdown_flag | hot_sd;
      EARLY_WARNING_FLAG_OUT    <= warn && !chip_off;
      ISO_FET_DISABLE_OUT       <= (SYSEN_MODE_IN == `SYSEN_WEAK_ISO) && !vin_ok &&
                                   BATTERY_MONITOR_ENABLE_BIT_IN && !above_weak;
      case (SYSEN_MODE_IN)
        `SYSEN_LDO:      SYSTEM_ENABLE_OUT <= !chip_off && vin_ok && sys_ok;
        `SYSEN_BAT:      SYSTEM_ENABLE_OUT <= above_weak && charger_mode;
        `SYSEN_WEAK_ISO: SYSTEM_ENABLE_OUT <= !vin_ok && BATTERY_MONITOR_ENABLE_BIT_IN &&
                                              !above_weak;
        default:         SYSTEM_ENABLE_OUT <= charger_mode ? above_weak
                                              : (vin_ok && !charge_en);
      endcase
    end
  end
  assign SYSTEM_ENABLE_OE_OUT = SYSTEM_ENABLE_OUT;

  always_comb begin
    if (chip_off) begin
      led_mode = chg_sup_pkg::LED_DARK;
    end else if (thermal_shutdown_flag) begin
      led_mode = chg_sup_pkg::LED_BLINK_HOT;
    end else if (state == chg_sup_pkg::CH_FAULT || state == chg_sup_pkg::CH_STOPPED) begin
      led_mode = chg_sup_pkg::LED_BLINK_FAULT;
    end else if (charger_mode) begin
      led_mode = chg_sup_pkg::LED_ON;
    end else begin
      led_mode = chg_sup_pkg::LED_DARK;
    end
  end

  led_pattern u_led (
    .clk    (CLK_IN),
    .rst_n  (rst_n),
    .mode   (led_mode),
    .led_on (led_on)
  );
  assign INDICATOR_OUTPUT_OUT    = 1'b0;
  assign INDICATOR_OUTPUT_OE_OUT = led_on;

  wd_start_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (WATCHDOG_KICK_BIT_IN && !chip_off) |=> wd_running && wd_cnt == 32'h0)
    else $error("watchdog not started by kick");
  safe_start_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (wd_expire && charger_mode && !chip_off && !safe_running) |=> safe_running)
    else $error("safety timer not started");
  ilim_def_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (wd_expire && charger_mode && !chip_off && !safe_running && CHARGE_PARAMS_SET_IN)
      |=> ILIM_DEFAULT_OUT)
    else $error("input limit not defaulted");
  done_flag_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    $rose(CHARGE_DONE_FLAG_OUT) |-> $past(end_cnt) == END_CYCLES)
    else $error("done before qualification");
  end_reset_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (!i_low) |=> end_cnt == 32'h0)
    else $error("end timer not restarted");
  chip_off_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    chip_off |=> !CHARGING_OUT && !REGULATOR_ON_OUT)
    else $error("charging while chip disabled");
  tsd_hold_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (thermal_shutdown_flag && !TSD_CLEAR_WRITE_IN) |=> thermal_shutdown_flag ##1 !CHARGING_OUT)
    else $error("shutdown flag lost");
  fault_code_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state == chg_sup_pkg::CH_FAULT) |-> CHARGE_STATE_OUT == `STATE_FAULT)
    else $error("fault code wrong");
  limit_hold_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state == chg_sup_pkg::CH_OFF && START_LIMIT_ENABLE_BIT_IN && above_lim)
      |=> state == chg_sup_pkg::CH_OFF)
    else $error("charge started above limit");
endmodule

// file: host_model.sv
// Host processor stand-in: periodic watchdog kicks and one-cycle writes.
// Assumes the supervisor samples all pulses on the rising clock edge.
module host_model (
  input  wire logic clk,
  input  wire logic kick_en,
  output logic      kick,
  output logic      en_write,
  output logic      fault_clr,
  output logic      tsd_clr
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap = 0;
  initial begin
    {kick, en_write, fault_clr, tsd_clr} = 4'h0;
  end
  // Kick every 8 cycles, well inside the shortened watchdog period
  always @(posedge clk) begin
    gap <= (gap == 7) ? 0 : gap + 1;
    kick <= kick_en && (gap == 7);
  end
  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: en_write <= 1'b1;
      1: fault_clr <= 1'b1;
      default: tsd_clr <= 1'b1;
    endcase
    @(posedge clk);
    {en_write, fault_clr, tsd_clr} <= 3'h0;
  endtask
endmodule

// file: charger_supervisor_logic_bench.sv
// Self-checking bench for the charger supervisor with shortened timers.
// Assumes the host model file is compiled first.
module charger_supervisor_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int END_C = 10;
  logic        clk;
  logic        rst_n;
  logic        kick_en;
  logic [10:0] h;
  logic [10:0] a;
  logic [1:0]  mode;
  logic [13:0] o;
  logic [2:0]  st;
  logic        kick, enw, fclr, tclr;
  logic [31:0] seed;
  int          failures = 0;
  int          comparisons = 0;
  int          m_on, m_ph, j;
  int          q[$];

  host_model u_host (.clk(clk), .kick_en(kick_en), .kick(kick), .en_write(enw),
    .fault_clr(fclr), .tsd_clr(tclr));

  charger_supervisor_logic #(.WD_CYCLES(32'd20), .SAFE_CYCLES(32'd50),
    .END_CYCLES(32'd10)) u_dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .WATCHDOG_KICK_BIT_IN(kick),
    .CHIP_DISABLE_BIT_IN(h[0]), .CHIP_DISABLE_PIN_EN_IN(h[1]),
    .CONFIG_PIN_TWO_IN(h[2]), .CHARGE_ENABLE_BIT_IN(h[3]),
    .CHARGE_ENABLE_WRITE_IN(enw), .CHARGE_PIN_EN_IN(h[4]),
    .CONFIG_PIN_THREE_IN(h[5]), .START_LIMIT_ENABLE_BIT_IN(h[6]),
    .RECHARGE_DISABLE_BIT_IN(h[7]), .CHARGE_PARAMS_SET_IN(h[8]),
    .BATTERY_MONITOR_ENABLE_BIT_IN(h[9]), .SYSEN_MODE_IN(mode),
    .FAULT_CLEAR_WRITE_IN(fclr), .TSD_CLEAR_WRITE_IN(tclr),
    .TIMER_FAULT_IN(h[10]), .BAT_ABOVE_WEAK_IN(a[0]), .BAT_ABOVE_TRICKLE_IN(a[1]),
    .BAT_ABOVE_START_LIMIT_IN(a[2]), .BAT_AT_TERMINATION_IN(a[3]),
    .BAT_SENSE_AT_RECHARGE_IN(a[4]), .CURRENT_BELOW_END_IN(a[5]),
    .SUPPLY_INPUT_OK_IN(a[6]), .SYSTEM_VOLTAGE_OK_IN(a[7]),
    .DIE_ABOVE_WARNING_IN(a[8]), .DIE_ABOVE_INTERRUPT_IN(a[9]),
    .DIE_ABOVE_SHUTDOWN_IN(a[10]), .CHARGE_STATE_OUT(st),
    .CHARGE_DONE_FLAG_OUT(o[0]), .RECHARGE_NEEDED_OUT(o[1]), .ILIM_DEFAULT_OUT(o[2]),
    .CHARGING_OUT(o[3]), .REGULATOR_ON_OUT(o[4]), .ISO_FET_DISABLE_OUT(o[5]),
    .SYSTEM_ENABLE_OUT(o[6]), .SYSTEM_ENABLE_OE_OUT(o[7]),
    .INDICATOR_OUTPUT_OUT(o[8]), .INDICATOR_OUTPUT_OE_OUT(o[9]),
    .THERMAL_SHUTDOWN_FLAG_OUT(o[10]), .EARLY_WARNING_FLAG_OUT(o[11]),
    .THERMAL_INT_OUT(o[12]));
  assign o[13] = 1'b0;

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected state code from the bench's own model
  function automatic logic [2:0] mst();
    return (m_on != 0) ? m_ph[2:0] : 3'h0;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wst(input logic [2:0] s);
    int i;
    for (i = 0; i < 200 && st !== s; i++)
      @(posedge clk);
  endtask

  // Compare off the edge, then realign so callers drive on the edge
  task automatic chk(input logic [13:0] m, input logic [13:0] e);
    #1;
    comparisons++;
    if (st !== mst() || (o & m) !== (e & m)) begin
      failures++;
      $display("mismatch at %0t: state %0d flags %h", $time, st, o);
    end
    @(posedge clk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    cyc(4000);
    failures++;
    end_sim();
  end

  initial begin
    {clk, rst_n, kick_en} = 3'h0;
    h = 11'h000;
    a = 11'h000;
    mode = 2'h0;
    m_on = 0;
    m_ph = 3;
    seed = 32'h0BC35E47;
    cyc(3);
    rst_n <= 1'b1;
    cyc(4);
    chk(14'h0405, 14'h0000);
    kick_en <= 1'b1;
    h <= 11'h108;
    a <= 11'h0CF;
    u_host.pulse(0);
    m_on = 1;
    wst(3);
    chk(14'h0208, 14'h0208);
    cyc(100);
    chk(14'h000C, 14'h0008);
    // Short random dips must not qualify; the long one must
    repeat (3) begin
      seed = lfsr(seed);
      q.push_back(1 + int'(seed[2:0]));
    end
    q.push_back(END_C + 20);
    foreach (q[k]) begin
      a[5] <= 1'b1;
      cyc(q[k]);
      a[5] <= 1'b0;
      if (q[k] >= END_C)
        m_ph = 4;
      cyc(12);
      chk(14'h0009, (m_ph == 4) ? 14'h0001 : 14'h0008);
    end
    h[7] <= 1'b1;
    a[4] <= 1'b1;
    cyc(8);
    chk(14'h000B, 14'h0003);
    h[7] <= 1'b0;
    m_ph = 3;
    wst(3);
    chk(14'h0008, 14'h0008);
    a[4] <= 1'b0;
    // Register write clears enable although the pin asks for charging
    h[3] <= 1'b0;
    u_host.pulse(0);
    m_on = 0;
    h[5:4] <= 2'h3;
    a[9:8] <= 2'h3;
    cyc(10);
    chk(14'h1A58, 14'h1850);
    mode <= 2'h3;
    cyc(8);
    chk(14'h0040, 14'h0040);
    a[9:8] <= 2'h0;
    h[3] <= 1'b1;
    u_host.pulse(0);
    m_on = 1;
    wst(3);
    chk(14'h0208, 14'h0208);
    for (j = 0; j < 2; j++) begin
      if (j == 0)
        h[0] <= 1'b1;
      else
        h[2:1] <= 2'h3;
      m_on = 0;
      cyc(10);
      chk(14'h0208, 14'h0000);
      h[2:0] <= 3'h0;
      m_on = 1;
      wst(3);
      chk(14'h0208, 14'h0208);
    end
    a[10] <= 1'b1;
    m_on = 0;
    cyc(10);
    chk(14'h0408, 14'h0400);
    u_host.pulse(2);
    cyc(8);
    chk(14'h0400, 14'h0400);
    a[10] <= 1'b0;
    cyc(8);
    chk(14'h0400, 14'h0400);
    u_host.pulse(2);
    m_on = 1;
    wst(3);
    chk(14'h0408, 14'h0008);
    kick_en <= 1'b0;
    cyc(40);
    chk(14'h0008, 14'h0008);
    m_ph = 5;
    wst(5);
    chk(14'h000C, 14'h0004);
    rst_n <= 1'b0;
    h[6] <= 1'b1;
    kick_en <= 1'b1;
    m_on = 0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(30);
    chk(14'h000C, 14'h0000);
    a[2] <= 1'b0;
    m_on = 1;
    m_ph = 3;
    wst(3);
    a[2] <= 1'b1;
    cyc(10);
    chk(14'h0008, 14'h0008);
    mode <= 2'h1;
    cyc(3);
    chk(14'h00C8, 14'h00C8);
    // Timer fault while charging, then cleared; the start limit keeps it off
    h[10] <= 1'b1;
    m_ph = 6;
    wst(6);
    cyc(2);
    chk(14'h0209, 14'h0200);
    h[10] <= 1'b0;
    u_host.pulse(1);
    m_on = 0;
    cyc(4);
    chk(14'h0008, 14'h0000);
    // Battery only, below weak, monitor on
    mode <= 2'h2;
    h[9] <= 1'b1;
    a[6] <= 1'b0;
    a[0] <= 1'b0;
    cyc(8);
    chk(14'h01F0, 14'h00E0);
    end_sim();
  end
endmodule
